// [hdl/amc_pkg.sv]
// constants and carrier types of the io control block
package amc_pkg;
    // clock and timing
    localparam int CLK_MHZ = 20;
    localparam int SPEED_PW_NS = 200000;
    localparam int SPEED_PW_CYC = (SPEED_PW_NS * CLK_MHZ + 999) / 1000;
    localparam int OVL_TICK_MS = 100;
    localparam int OVL_TICK_CYC = OVL_TICK_MS * CLK_MHZ * 1000;
    localparam int OVL_CAP_MS = 5000;
    localparam logic [15:0] OVL_CAP_TENTHS = 16'(OVL_CAP_MS / OVL_TICK_MS);
    localparam int INIT_MS = 1000;
    localparam int INIT_CYC = INIT_MS * CLK_MHZ * 1000;
    localparam int BLINK_BIT = 21;
    // register bus
    localparam int AW = 4;
    localparam int DW = 16;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OVL_TIME = 4'h1;
    localparam logic [3:0] ADDR_WARN_LEVEL = 4'h2;
    localparam logic [3:0] ADDR_BAND = 4'h3;
    localparam logic [3:0] ADDR_RATIO = 4'h4;
    localparam logic [3:0] ADDR_INIT = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    // control register fields
    localparam int CTRL_TA_LSB = 0;
    localparam int CTRL_TB_LSB = 3;
    localparam int CTRL_HOLD_BIT = 6;
    localparam int INIT_GO_BIT = 0;
    // status register fields
    localparam int STS_ALARM_BIT = 0;
    localparam int STS_CODE_LSB = 1;
    localparam int STS_RUN_BIT = 3;
    localparam int STS_WARN_BIT = 4;
    localparam int STS_REACHED_BIT = 5;
    localparam int STS_INIT_BIT = 6;
    localparam int STS_DSEL_LSB = 7;
    // output terminal functions
    typedef enum logic [2:0] {
        FN_UNUSED = 3'h0,
        FN_FAULT = 3'h1,
        FN_SPEED = 3'h2,
        FN_OVL = 3'h3,
        FN_RUN = 3'h4,
        FN_REACHED = 3'h5,
        FN_WARN = 3'h6
    } amc_fn_t;
    // alarm codes shown on the display
    localparam logic [1:0] CODE_NONE = 2'h0;
    localparam logic [1:0] CODE_EXT = 2'h1;
    localparam logic [1:0] CODE_OVL = 2'h2;
    // factory values; overload time in tenths of a second (30.0 s)
    localparam amc_fn_t TA_RST = FN_SPEED;
    localparam amc_fn_t TB_RST = FN_FAULT;
    localparam logic [15:0] OVL_TIME_RST = 16'h012c;
    localparam logic [15:0] WARN_RST = 16'h0078;
    localparam logic [15:0] BAND_RST = 16'h00c8;
    localparam logic [15:0] BAND_MAX = 16'h0190;
    localparam logic [15:0] RATIO_UNITY = 16'h0064;
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_ALARM = 2'b01,
        ST_INIT = 2'b11
    } amc_mode_t;
    typedef struct packed {
        logic run_cw;
        logic run_ccw;
        logic sel_hi;
        logic sel_lo;
        logic fault_clear;
        logic ext_ok;
        logic hold_release;
    } amc_pins_t;
    localparam amc_pins_t PINS_RST = 7'h02;
    typedef struct packed {
        logic [15:0] load_pct;
        logic [15:0] speed_rpm;
        logic [15:0] target_rpm;
        logic limited_ovl;
        logic beyond_ovl;
        logic shaft_locked;
        logic rev_tick;
    } amc_motor_t;
    typedef struct packed {
        amc_fn_t term_a;
        amc_fn_t term_b;
        logic hold_en;
        logic [15:0] ovl_time;
        logic [15:0] warn_level;
        logic [15:0] band;
        logic [15:0] ratio;
    } amc_cfg_t;
    localparam amc_cfg_t CFG_RST = '{TA_RST, TB_RST, 1'b0, OVL_TIME_RST, WARN_RST,
                                     BAND_RST, RATIO_UNITY};
    typedef struct packed {
        amc_pins_t s1;
        amc_pins_t s2;
        amc_pins_t s3;
        amc_pins_t pins;
        logic clr_prev;
        amc_cfg_t cfg;
        amc_mode_t mode;
        logic [1:0] code;
        logic [20:0] tick_cnt;
        logic [15:0] ovl_cnt;
        logic [11:0] spd_cnt;
        logic [24:0] init_cnt;
        logic motor_run;
        logic motor_ccw;
        logic stop_now;
        logic [1:0] data_number;
        logic hold_active;
        logic fault_flag;
        logic overload_flag;
        logic speed_reached;
        logic warning;
        logic term_a_out;
        logic term_b_out;
        logic blink;
        logic ratio_inc;
        logic [15:0] rdata;
    } amc_state_t;
endpackage : amc_pkg

// [hdl/amc_io_control.sv]
// run, alarm, overload and output-terminal logic
`timescale 1ns/1ns
// What this block does
// (R01) exactly one run input on turns the motor
// (R02) both run inputs on stop the motor at once
// (R03) select inputs form the data number; both off picks zero
// (R04) a rising fault-clear input resets the present alarm
// (R05) fault input off: alarm, instant stop, external code
// (R06) hold release frees standstill hold when enabled
// (R07) fault flag is normally closed, opens during an alarm
// (R08) each terminal takes one of seven functions; defaults speed, fault
// (R09) overload alarm only after the condition lasts the set time, default 30.0 s
// (R10) beyond limited region or locked shaft caps the overload delay at 5 s
// (R11) load factor against warning level, default 120 percent
// (R12) speed reached band is 0 to 400 r/min, default 200
// (R13) initialize restores factory settings; display blinks while it runs
// (R14) ratio exactly 1.00 selects reduction, else increase
// (R15) the operator keeps motor power on while initialization is blinking
// (R16) speed pulse: one 0.2 ms pulse per thirtieth of a shaft turn
// (R17) overload flag, normally closed, opens on warning or overload alarm
// (R18) speed reached when running and speed is within the band of setpoint
// (R19) warning output follows its condition, clears by itself
// (R20) alarm stays latched, motor stopped, until cleared and cause removed
module amc_io_control
    import amc_pkg::*;
#(
    parameter int OVL_TICK = OVL_TICK_CYC,
    parameter int INIT_LEN = INIT_CYC
) (
    // clock, reset, enable
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DW-1:0] reg_rdata,
    // discrete input terminals
    input wire logic run_cw_in,
    input wire logic run_ccw_in,
    input wire logic data_select_lo,
    input wire logic data_select_hi,
    input wire logic fault_clear_in,
    input wire logic external_fault_in,
    input wire logic hold_release_in,
    // motor feedback from the drive logic
    input wire amc_motor_t motor_fb,
    // motor commands
    output logic motor_run,
    output logic motor_ccw,
    output logic motor_stop_now,
    output logic [1:0] data_number,
    output logic hold_active,
    output logic ratio_increase,
    // discrete outputs and display
    output logic fault_flag_out,
    output logic overload_flag_out,
    output logic speed_reached_out,
    output logic warning_out,
    output logic terminal_a_out,
    output logic terminal_b_out,
    output logic [1:0] display_code,
    output logic display_blink
);

    amc_state_t state_ff;
    amc_state_t nxt_state;
    amc_pins_t pins_raw;
    logic clr_rise;
    logic tick;
    logic ovl_cond;
    logic ovl_trip;
    logic ext_trip;
    logic init_req;
    logic [15:0] ovl_limit;
    logic [15:0] spd_diff;
    logic [DW-1:0] status_word;

    // one decoder feeds both output terminals
    function automatic logic term_drive(input amc_fn_t fn, input amc_state_t s);
        logic v;
        v = 1'b0;
        unique case (fn)
            FN_UNUSED: v = 1'b0;
            FN_FAULT: v = s.fault_flag;
            FN_SPEED: v = s.spd_cnt != 12'h000;
            FN_OVL: v = s.overload_flag;
            FN_RUN: v = s.motor_run;
            FN_REACHED: v = s.speed_reached;
            FN_WARN: v = s.warning;
            default: v = 1'b0;
        endcase
        return v;
    endfunction : term_drive

    assign pins_raw = '{run_cw_in, run_ccw_in, data_select_hi, data_select_lo,
                        fault_clear_in, external_fault_in, hold_release_in};

    always_comb begin
        nxt_state = state_ff;
        clr_rise = 1'b0;
        tick = 1'b0;
        ovl_cond = 1'b0;
        ovl_trip = 1'b0;
        ext_trip = 1'b0;
        init_req = 1'b0;
        ovl_limit = 16'h0000;
        spd_diff = 16'h0000;
        status_word = '0;

        // pins settle only when the second and third stages agree
        nxt_state.s1 = pins_raw;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        if (state_ff.s2 == state_ff.s3) begin
            nxt_state.pins = state_ff.s3;
        end
        // (R04) clear acts on the rising edge only
        clr_rise = state_ff.pins.fault_clear & ~state_ff.clr_prev;
        nxt_state.clr_prev = state_ff.pins.fault_clear;

        // (R05) normally closed input: low means fault
        ext_trip = ~state_ff.pins.ext_ok;

        // overload time base in tenths of a second
        tick = state_ff.tick_cnt == 21'(OVL_TICK - 1);
        nxt_state.tick_cnt = tick ? 21'h000000 : state_ff.tick_cnt + 21'h000001;
        ovl_cond = motor_fb.limited_ovl | motor_fb.beyond_ovl | motor_fb.shaft_locked;
        // (R10) heavy overload or locked shaft never waits beyond 5 s
        if ((motor_fb.beyond_ovl | motor_fb.shaft_locked)
                && state_ff.cfg.ovl_time > OVL_CAP_TENTHS) begin
            ovl_limit = OVL_CAP_TENTHS;
        end else begin
            ovl_limit = state_ff.cfg.ovl_time;
        end
        // (R09) count persistence; any break in the condition restarts it
        if (!ovl_cond) begin
            nxt_state.ovl_cnt = 16'h0000;
        end else if (tick && state_ff.ovl_cnt < ovl_limit) begin
            nxt_state.ovl_cnt = state_ff.ovl_cnt + 16'h0001;
        end
        ovl_trip = ovl_cond && state_ff.ovl_cnt >= ovl_limit;

        // register writes; refused while initialization runs
        if (reg_wr && state_ff.mode != ST_INIT) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    // (R08) terminal function assignment
                    nxt_state.cfg.term_a = amc_fn_t'(reg_wdata[CTRL_TA_LSB +: 3]);
                    nxt_state.cfg.term_b = amc_fn_t'(reg_wdata[CTRL_TB_LSB +: 3]);
                    nxt_state.cfg.hold_en = reg_wdata[CTRL_HOLD_BIT];
                end
                ADDR_OVL_TIME: nxt_state.cfg.ovl_time = reg_wdata;
                ADDR_WARN_LEVEL: nxt_state.cfg.warn_level = reg_wdata;
                // (R12) band is clamped to its 400 r/min ceiling
                ADDR_BAND: nxt_state.cfg.band = (reg_wdata > BAND_MAX) ? BAND_MAX : reg_wdata;
                ADDR_RATIO: nxt_state.cfg.ratio = reg_wdata;
                ADDR_INIT: init_req = reg_wdata[INIT_GO_BIT];
                default: ;
            endcase
        end

        // alarm and initialization sequencing
        unique case (state_ff.mode)
            ST_NORMAL: begin
                if (ext_trip) begin
                    nxt_state.mode = ST_ALARM;
                    nxt_state.code = CODE_EXT;
                end else if (ovl_trip) begin
                    nxt_state.mode = ST_ALARM;
                    nxt_state.code = CODE_OVL;
                end else if (init_req) begin
                    // (R13) restore every setting at once, then hold the blink
                    nxt_state.mode = ST_INIT;
                    nxt_state.cfg = CFG_RST;
                    nxt_state.init_cnt = '0;
                end
            end
            ST_ALARM: begin
                // (R20) a live cause keeps the latch; set wins over clear
                if (clr_rise && !ext_trip && !ovl_trip) begin
                    nxt_state.mode = ST_NORMAL;
                    nxt_state.code = CODE_NONE;
                end
            end
            ST_INIT: begin
                nxt_state.init_cnt = state_ff.init_cnt + 25'h0000001;
                if (ext_trip) begin
                    nxt_state.mode = ST_ALARM;
                    nxt_state.code = CODE_EXT;
                end else if (state_ff.init_cnt == 25'(INIT_LEN - 1)) begin
                    nxt_state.mode = ST_NORMAL;
                end
            end
            default: begin
                nxt_state.mode = ST_NORMAL;
                nxt_state.code = CODE_NONE;
            end
        endcase

        // (R01) exactly one run input turns the motor
        nxt_state.motor_run = nxt_state.mode == ST_NORMAL
                              && (state_ff.pins.run_cw ^ state_ff.pins.run_ccw);
        nxt_state.motor_ccw = state_ff.pins.run_ccw & ~state_ff.pins.run_cw;
        // (R02) both inputs or any alarm brake at once
        nxt_state.stop_now = (state_ff.pins.run_cw & state_ff.pins.run_ccw)
                             | (nxt_state.mode == ST_ALARM);
        // (R03) operation data number
        nxt_state.data_number = {state_ff.pins.sel_hi, state_ff.pins.sel_lo};
        // (R06) hold only at standstill and only while not released
        nxt_state.hold_active = nxt_state.cfg.hold_en && !nxt_state.motor_run
                                && !state_ff.pins.hold_release;
        // (R14) exact unity selects reduction
        nxt_state.ratio_inc = nxt_state.cfg.ratio != RATIO_UNITY;

        // (R11) load factor against warning level
        // (R19) warning tracks the condition with no latch
        nxt_state.warning = motor_fb.load_pct > state_ff.cfg.warn_level;
        // (R07) closed while healthy, open on alarm
        nxt_state.fault_flag = nxt_state.mode != ST_ALARM;
        // (R17) opens on warning level or overload alarm
        nxt_state.overload_flag = !(nxt_state.warning
                                    || (nxt_state.mode == ST_ALARM
                                        && nxt_state.code == CODE_OVL));
        // (R18) within band of setpoint while running
        spd_diff = (motor_fb.speed_rpm >= motor_fb.target_rpm)
                   ? motor_fb.speed_rpm - motor_fb.target_rpm
                   : motor_fb.target_rpm - motor_fb.speed_rpm;
        nxt_state.speed_reached = nxt_state.motor_run && spd_diff <= state_ff.cfg.band;

        // (R16) fixed-width pulse per rotation tick; a tick restarts it
        if (motor_fb.rev_tick && state_ff.motor_run) begin
            nxt_state.spd_cnt = 12'(SPEED_PW_CYC);
        end else if (state_ff.spd_cnt != 12'h000) begin
            nxt_state.spd_cnt = state_ff.spd_cnt - 12'h001;
        end

        // (R08) terminals follow the chosen function, one cycle behind it
        nxt_state.term_a_out = term_drive(state_ff.cfg.term_a, state_ff);
        nxt_state.term_b_out = term_drive(state_ff.cfg.term_b, state_ff);

        // (R13) blink while restoring; (R15) power must stay on meanwhile
        nxt_state.blink = nxt_state.mode == ST_INIT && nxt_state.init_cnt[BLINK_BIT];

        status_word[STS_ALARM_BIT] = state_ff.mode == ST_ALARM;
        status_word[STS_CODE_LSB +: 2] = state_ff.code;
        status_word[STS_RUN_BIT] = state_ff.motor_run;
        status_word[STS_WARN_BIT] = state_ff.warning;
        status_word[STS_REACHED_BIT] = state_ff.speed_reached;
        status_word[STS_INIT_BIT] = state_ff.mode == ST_INIT;
        status_word[STS_DSEL_LSB +: 2] = state_ff.data_number;

        // read data stand for one cycle only; unmapped reads give zero
        nxt_state.rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CTRL: begin
                    nxt_state.rdata[CTRL_TA_LSB +: 3] = state_ff.cfg.term_a;
                    nxt_state.rdata[CTRL_TB_LSB +: 3] = state_ff.cfg.term_b;
                    nxt_state.rdata[CTRL_HOLD_BIT] = state_ff.cfg.hold_en;
                end
                ADDR_OVL_TIME: nxt_state.rdata = state_ff.cfg.ovl_time;
                ADDR_WARN_LEVEL: nxt_state.rdata = state_ff.cfg.warn_level;
                ADDR_BAND: nxt_state.rdata = state_ff.cfg.band;
                ADDR_RATIO: nxt_state.rdata = state_ff.cfg.ratio;
                ADDR_STATUS: nxt_state.rdata = status_word;
                default: nxt_state.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_ff <= '0;
            // the fault input idles closed, so reset must not look like a fault
            state_ff.s1 <= PINS_RST;
            state_ff.s2 <= PINS_RST;
            state_ff.s3 <= PINS_RST;
            state_ff.pins <= PINS_RST;
            state_ff.cfg <= CFG_RST;
            state_ff.mode <= ST_NORMAL;
            state_ff.fault_flag <= 1'b1;
            state_ff.overload_flag <= 1'b1;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rdata = state_ff.rdata;
    assign motor_run = state_ff.motor_run;
    assign motor_ccw = state_ff.motor_ccw;
    assign motor_stop_now = state_ff.stop_now;
    assign data_number = state_ff.data_number;
    assign hold_active = state_ff.hold_active;
    assign ratio_increase = state_ff.ratio_inc;
    assign fault_flag_out = state_ff.fault_flag;
    assign overload_flag_out = state_ff.overload_flag;
    assign speed_reached_out = state_ff.speed_reached;
    assign warning_out = state_ff.warning;
    assign terminal_a_out = state_ff.term_a_out;
    assign terminal_b_out = state_ff.term_b_out;
    assign display_code = state_ff.code;
    assign display_blink = state_ff.blink;

endmodule : amc_io_control

// [verif/amc_drive_model.sv]
// model of the drive: load, speed and shaft ticks
`timescale 1ns/1ns
module amc_drive_model
    import amc_pkg::*;
#(
    parameter int TICK_GAP = 6000
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // command from the block
    input wire logic motor_run,
    // {locked, beyond, limited}
    input wire logic [2:0] ovl_cond,
    input wire logic [15:0] load,
    input wire logic [15:0] speed,
    input wire logic [15:0] target,
    // feedback
    output amc_motor_t motor_fb
);
    logic [12:0] gap_ff;
    logic tick;
    assign tick = motor_run && (gap_ff == 13'(TICK_GAP - 1));
    always_ff @(posedge sys_clk) begin
        if (!rstn || !motor_run || tick) begin
            gap_ff <= '0;
        end else begin
            gap_ff <= gap_ff + 13'h1;
        end
    end
    assign motor_fb = '{load, speed, target, ovl_cond[0], ovl_cond[1], ovl_cond[2], tick};
endmodule : amc_drive_model

// [verif/amc_io_control_sva.sv]
// concurrent checks on the ports of the io control block
`timescale 1ns/1ns
module amc_io_control_sva
    import amc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // terminals
    input wire logic run_cw_in,
    input wire logic run_ccw_in,
    input wire logic data_select_lo,
    input wire logic data_select_hi,
    input wire logic fault_clear_in,
    input wire logic external_fault_in,
    input wire amc_motor_t motor_fb,
    // outputs
    input wire logic motor_run,
    input wire logic motor_ccw,
    input wire logic motor_stop_now,
    input wire logic [1:0] data_number,
    input wire logic fault_flag_out,
    input wire logic overload_flag_out,
    input wire logic warning_out,
    input wire logic [1:0] display_code
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // cycles since the clear input was last seen high, saturating
    logic [3:0] clr_age_ff;
    always_ff @(posedge sys_clk) begin
        if (!rstn || fault_clear_in) begin
            clr_age_ff <= 4'h0;
        end else if (clr_age_ff != 4'hf) begin
            clr_age_ff <= clr_age_ff + 4'h1;
        end
    end
    sequence s_cw_only;
        (run_cw_in && !run_ccw_in)[*6] ##0 fault_flag_out[*2];
    endsequence
    sequence s_both_on;
        (run_cw_in && run_ccw_in)[*6];
    endsequence
    sequence s_ext_off;
        (!external_fault_in)[*6];
    endsequence
    AST_CW_RUNS: assert property (s_cw_only |-> motor_run && !motor_ccw)
        else $error("no run on one input");
    AST_BOTH_STOP: assert property (s_both_on |-> motor_stop_now && !motor_run)
        else $error("no stop on both inputs");
    AST_DATA_SEL: assert property ($stable({data_select_hi, data_select_lo})[*6]
        |-> data_number == {data_select_hi, data_select_lo})
        else $error("data number wrong");
    AST_EXT_ALARM: assert property (s_ext_off |-> !fault_flag_out && display_code == CODE_EXT)
        else $error("external fault not raised");
    AST_ALARM_STOP: assert property (!fault_flag_out |-> motor_stop_now && !motor_run)
        else $error("motor runs in alarm");
    AST_CLEAR_CAUSE: assert property ($rose(fault_flag_out) |-> clr_age_ff <= 4'ha)
        else $error("alarm left without clear");
    AST_WARN_OVL: assert property ($rose(warning_out) |-> ##[0:1] !overload_flag_out)
        else $error("overload flag closed during warning");
    AST_WARN_SET: assert property ((motor_fb.load_pct > WARN_RST)[*3] |-> warning_out)
        else $error("warning missing above level");
    AST_WARN_DROP: assert property ((motor_fb.load_pct <= WARN_RST)[*3] |-> !warning_out)
        else $error("warning stays after load fell");
endmodule : amc_io_control_sva
bind amc_io_control amc_io_control_sva amc_io_control_sva_inst (.sys_clk, .rstn, .run_cw_in,
    .run_ccw_in, .data_select_lo, .data_select_hi, .fault_clear_in, .external_fault_in,
    .motor_fb, .motor_run, .motor_ccw, .motor_stop_now, .data_number, .fault_flag_out,
    .overload_flag_out, .warning_out, .display_code);

// [verif/agitator_motor_io_control_bench.sv]
// self-checking bench
`timescale 1ns/1ns
module agitator_motor_io_control_bench;
    import amc_pkg::*;
    localparam int OT = 10;
    logic sys_clk = 1'b0, rstn = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0, reg_rdata, v, load = 16'h0, speed = 16'h0, target = 16'h0;
    logic [2:0] ovl_cond = 3'h0;
    // pin order {cw, ccw, sel_hi, sel_lo, clear, ext_ok, hold_release}
    amc_pins_t p = 7'h02;
    amc_motor_t motor_fb;
    logic motor_run, motor_ccw, motor_stop_now, hold_active, ratio_increase, fault_flag_out;
    logic overload_flag_out, speed_reached_out, warning_out, terminal_a_out, terminal_b_out;
    logic display_blink;
    logic [1:0] data_number, display_code;
    int fails = 0, n_tests = 0, n, m;
    initial forever #25 sys_clk = ~sys_clk;
    amc_io_control #(.OVL_TICK(OT), .INIT_LEN(8)) amc_io_control_inst (.sys_clk, .rstn, .ce,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .run_cw_in(p.run_cw),
        .run_ccw_in(p.run_ccw), .data_select_lo(p.sel_lo), .data_select_hi(p.sel_hi),
        .fault_clear_in(p.fault_clear), .external_fault_in(p.ext_ok),
        .hold_release_in(p.hold_release), .motor_fb, .motor_run, .motor_ccw, .motor_stop_now,
        .data_number, .hold_active, .ratio_increase, .fault_flag_out, .overload_flag_out,
        .speed_reached_out, .warning_out, .terminal_a_out, .terminal_b_out, .display_code,
        .display_blink);
    amc_drive_model amc_drive_model_inst (.sys_clk, .rstn, .motor_run, .ovl_cond, .load, .speed,
        .target, .motor_fb);
    task automatic final_report();
        if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic pins(input amc_pins_t q);
        @(posedge sys_clk);
        p <= q;
        tick(8);
    endtask : pins
    // bounded wait for an alarm
    task automatic wait_fault(input int lim);
        n = 0;
        while (fault_flag_out !== 1'b0 && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) begin
            fails++;
            final_report();
        end
    endtask : wait_fault
    task automatic clear_alarm();
        pins(7'h06);
        chk("fault held while overloaded", 16'h0, 16'(fault_flag_out));
        @(posedge sys_clk);
        ovl_cond <= 3'h0;
        pins(7'h02);
        pins(7'h06);
        chk("fault flag after clear", 16'h1, 16'(fault_flag_out));
        pins(7'h02);
    endtask : clear_alarm
    initial begin
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        tick(2);
        chk("fault flag idle", 16'h1, 16'(fault_flag_out));
        chk("overload flag idle", 16'h1, 16'(overload_flag_out));
        rd(ADDR_CTRL, v); chk("ctrl reset", 16'h000a, v);
        rd(ADDR_OVL_TIME, v); chk("ovl time reset", 16'h012c, v);
        rd(ADDR_WARN_LEVEL, v); chk("warn reset", 16'h0078, v);
        rd(ADDR_BAND, v); chk("band reset", 16'h00c8, v);
        rd(ADDR_RATIO, v); chk("ratio reset", 16'h0064, v);
        rd(4'hf, v); chk("unmapped read", 16'h0, v);
        wr(ADDR_BAND, 16'h01f4); rd(ADDR_BAND, v); chk("band clamp", BAND_MAX, v);
        wr(ADDR_RATIO, 16'h0065); tick(2); chk("ratio inc", 16'h1, 16'(ratio_increase));
        wr(ADDR_RATIO, 16'h0064); tick(2); chk("ratio red", 16'h0, 16'(ratio_increase));
        pins(7'h42); chk("cw run", 16'h2, 16'({motor_run, motor_ccw}));
        pins(7'h22); chk("ccw run", 16'h3, 16'({motor_run, motor_ccw}));
        pins(7'h62); chk("both stop", 16'h1, 16'({motor_run, motor_stop_now}));
        for (int i = 0; i < 4; i++) begin
            pins(7'h02 | 7'(i << 3)); chk("data number", 16'(i), 16'(data_number));
        end
        wr(ADDR_CTRL, 16'h004a); tick(2); chk("hold on", 16'h1, 16'(hold_active));
        pins(7'h03); chk("hold freed", 16'h0, 16'(hold_active));
        wr(ADDR_CTRL, 16'h000a); pins(7'h42);
        @(posedge sys_clk); target <= 16'd1000;
        // fn 2 (speed pulse) is checked below
        for (int f = 0; f < 8; f++) begin
            if (f == 2) continue;
            wr(ADDR_CTRL, 16'((f << 3) | f)); tick(3);
            chk("term a fn", 16'(8'h1a >> f) & 16'h1, 16'(terminal_a_out));
            chk("term b fn", 16'(8'h1a >> f) & 16'h1, 16'(terminal_b_out));
        end
        wr(ADDR_CTRL, 16'h000a);
        n = 0;
        while (terminal_a_out !== 1'b1 && n < 7000) begin tick(1); n++; end
        m = 0;
        while (terminal_a_out === 1'b1 && m < 5000) begin tick(1); m++; end
        chk("speed pulse width", 16'(SPEED_PW_CYC), 16'(m));
        @(posedge sys_clk); speed <= 16'd1400; tick(3);
        chk("reached at band edge", 16'h1, 16'(speed_reached_out));
        @(posedge sys_clk); speed <= 16'd1401; tick(3);
        chk("reached outside band", 16'h0, 16'(speed_reached_out));
        @(posedge sys_clk); load <= 16'd121; tick(3);
        chk("warning set", 16'h1, 16'(warning_out));
        chk("overload flag open", 16'h0, 16'(overload_flag_out));
        @(posedge sys_clk); load <= 16'd120; tick(3);
        chk("warning gone", 16'h0, 16'(warning_out));
        chk("overload flag closed", 16'h1, 16'(overload_flag_out));
        wr(ADDR_OVL_TIME, 16'h0005);
        @(posedge sys_clk); ovl_cond <= 3'h1;
        wait_fault(200);
        chk("limited trip time", 16'h1, 16'(n >= 4 * OT - 1 && n <= 5 * OT + 3));
        chk("overload code", 16'(CODE_OVL), 16'(display_code));
        clear_alarm();
        wr(ADDR_OVL_TIME, 16'h012c);
        @(posedge sys_clk); ovl_cond <= 3'h2;
        wait_fault(1000);
        chk("capped trip time", 16'h1, 16'(n >= 49 * OT - 1 && n <= 50 * OT + 3));
        clear_alarm();
        pins(7'h40);
        chk("ext alarm", 16'h1, 16'({fault_flag_out, motor_run, display_code}));
        pins(7'h44); chk("clear with cause", 16'h0, 16'(fault_flag_out));
        pins(7'h42); chk("latched", 16'h0, 16'(fault_flag_out));
        pins(7'h46); chk("cleared and running", 16'h3, 16'({fault_flag_out, motor_run}));
        pins(7'h02);
        // initialization restores the factory settings and refuses writes while busy
        wr(ADDR_CTRL, 16'h0000); wr(ADDR_INIT, 16'h0001);
        rd(ADDR_STATUS, v); chk("init busy", 16'h1, 16'(v[STS_INIT_BIT]));
        wr(ADDR_BAND, 16'h0010);
        tick(20);
        rd(ADDR_CTRL, v); chk("ctrl restored", 16'h000a, v);
        rd(ADDR_BAND, v); chk("band restored", 16'h00c8, v);
        final_report();
    end
endmodule : agitator_motor_io_control_bench
